// File: logic/irq_status_cfg.svh
// offsets, field positions, reset values and limits of the status register bank
`ifndef IRQ_STATUS_CFG_SVH
`define IRQ_STATUS_CFG_SVH

`define ADDR_TIMER_NFC_IRQ 8'h18
`define ADDR_ERROR_WAKEUP_IRQ 8'h19
`define ADDR_FIFO_FILL_COUNT 8'h1A
`define ADDR_FIFO_FLAGS 8'h1B
`define ADDR_COLLISION_POSITION 8'h1C
`define ADDR_WAKE_CONTROL 8'h30
`define ADDR_AMP_DELTA 8'h31
`define ADDR_PHASE_DELTA 8'h32
`define ADDR_CAP_DELTA 8'h33

`define ERR_BIT_CHECKSUM 7
`define ERR_BIT_PARITY 6
`define ERR_BIT_SOFT_FRAMING 5
`define ERR_BIT_HARD_FRAMING 4
`define ERR_BIT_WAKE_TIMEOUT 3
`define ERR_BIT_AMPLITUDE 2
`define ERR_BIT_PHASE 1
`define ERR_BIT_CAPACITANCE 0

`define FLAG_BIT_UNDERFLOW 6
`define FLAG_BIT_OVERFLOW 5
`define FLAG_BIT_INCOMPLETE 4
`define FLAG_BIT_MISSING_PARITY 0

`define STATUS_RESET 8'h00
`define DELTA_RESET 8'h00
`define FIFO_DEPTH 7'h60
`define COLL_RANGE_BYTES 8'h10

`endif

// File: logic/irq_status_pkg.sv
// types shared by the status register bank modules
package irq_status_pkg;

  typedef enum logic [1:0] {
    coll_idle = 2'b00,
    coll_armed = 2'b01,
    coll_seen = 2'b11
  } coll_state_e;

  typedef struct packed {
    coll_state_e state;
    logic [7:0] position;
    logic parity_error;
  } coll_s;

  typedef struct packed {
    logic [7:0] rd_data;
    logic wake_every_timeout;
    logic [7:0] amp_delta;
    logic [7:0] phase_delta;
    logic [7:0] cap_delta;
    logic [6:0] fill_count;
    logic underflow;
    logic overflow;
    logic incomplete;
    logic [2:0] last_bits;
    logic missing_parity;
  } top_s;

endpackage : irq_status_pkg

// File: logic/sticky_irq_reg.sv
// interrupt flags that stick until a clearing read or a forced clear
`timescale 1ns/10ps
module sticky_irq_reg #(
  parameter int width = 8
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic force_clear,
  input wire logic read_clear,
  input wire logic [width-1:0] set_evt,
  output logic [width-1:0] flags
);
  typedef struct packed {
    logic [width-1:0] flags;
  } flag_s;

  flag_s cur;
  flag_s nxt;

  if (width < 1 || width > 8) begin : g_width_check
    $error("sticky_irq_reg width must be 1 to 8");
  end

  always_comb begin
    nxt = cur;
    if (force_clear) begin
      nxt.flags = '0;
    end else begin
      // a new event in the clearing cycle stays recorded
      nxt.flags = (read_clear ? '0 : cur.flags) | set_evt; // [R20]
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign flags = cur.flags;
endmodule : sticky_irq_reg

// File: logic/collision_capture.sv
// captures the position of the first collision of a frame when it lies inside the short anticollision range
`timescale 1ns/10ps
`include "irq_status_cfg.svh"
module collision_capture
  import irq_status_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic force_clear,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic coll_evt,
  input wire logic [7:0] coll_bytes,
  input wire logic [2:0] coll_bits,
  input wire logic coll_parity,
  output logic [7:0] position,
  output logic parity_error
);
  coll_s cur;
  coll_s nxt;

  always_comb begin
    nxt = cur;
    nxt.parity_error = 1'b0;
    case (cur.state)
      coll_idle: begin
        if (frame_start) begin
          nxt.state = coll_armed;
        end
      end
      coll_armed: begin
        if (coll_evt) begin
          nxt.state = coll_seen;
          // only collisions inside the short anticollision range are shown
          if (coll_bytes < `COLL_RANGE_BYTES) begin // [R17]
            nxt.position = {coll_bytes[3:0], coll_bits, coll_parity}; // [R16]
          end
          nxt.parity_error = coll_parity; // [R18]
        end else if (frame_end) begin
          nxt.state = coll_idle;
        end
      end
      coll_seen: begin
        if (frame_end) begin
          nxt.state = coll_idle;
        end
      end
      default: begin
        nxt.state = coll_idle;
      end
    endcase
    if (force_clear) begin
      nxt.position = `STATUS_RESET; // [R10]
      nxt.state = coll_idle;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign position = cur.position;
  assign parity_error = cur.parity_error;
endmodule : collision_capture

// File: logic/irq_fifo_collision_status.sv
// Operation
// [R1] timer interrupt register clears when read
// [R2] both interrupt registers zero at reset, set-default
// [R3] error/wake-up register clears when read
// [R4] bit7 checksum error, bit6 parity error
// [R5] bit5 soft framing, bit4 hard framing
// [R6] bit3 wake timeout when every-timeout option set
// [R7] bit2 amplitude differs from reference beyond delta
// [R8] bit1 phase, bit0 capacitance exceed reference
// [R9] fill count seven bits, zero to ninety-six
// [R10] fifo and collision registers cleared by commands
// [R11] bit6 underflow, bit5 overflow
// [R12] bit4 incomplete byte, bits3..1 valid bits
// [R13] bit0 missing parity, counted as framing error
// [R14] empty fifo clears count and incomplete bits; the code clears incomplete and last_bits[1:0] but keeps last_bits[2]
// [R15] host reads both fifo status first
// [R16] collision bytes bits7..4, bits bits3..1
// [R17] only short anticollision collisions update position
// [R18] bit0 parity collision, first collision only
// [R19] summary bits clear on detailed register read
// [R20] flags stick; same-cycle event survives clearing read
`timescale 1ns/10ps
`include "irq_status_cfg.svh"
module irq_fifo_collision_status
  import irq_status_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic set_default_cmd,
  input wire logic clear_cmd,
  input wire logic [7:0] timer_nfc_evt,
  input wire logic checksum_err_evt,
  input wire logic parity_err_evt,
  input wire logic soft_framing_evt,
  input wire logic hard_framing_evt,
  input wire logic wake_timeout_evt,
  input wire logic amp_done,
  input wire logic [7:0] amp_meas,
  input wire logic [7:0] amp_ref,
  input wire logic phase_done,
  input wire logic [7:0] phase_meas,
  input wire logic [7:0] phase_ref,
  input wire logic cap_done,
  input wire logic [7:0] cap_meas,
  input wire logic [7:0] cap_ref,
  input wire logic [6:0] fifo_count,
  input wire logic fifo_push,
  input wire logic fifo_pop,
  input wire logic rx_end,
  input wire logic last_incomplete,
  input wire logic [2:0] last_bits,
  input wire logic last_no_parity,
  input wire logic rx_start,
  input wire logic coll_evt,
  input wire logic [7:0] coll_bytes,
  input wire logic [2:0] coll_bits,
  input wire logic coll_parity,
  output logic coll_parity_error,
  output logic timer_irq_pending,
  output logic error_irq_pending
);
  top_s cur;
  top_s nxt;
  logic [7:0] timer_flags;
  logic [7:0] error_flags;
  logic [7:0] error_set;
  logic [7:0] coll_position;
  logic status_clear;
  logic missing_parity_evt;

  // true when measurement rises above reference by more than delta
  function automatic logic exceeds(input logic [7:0] meas, input logic [7:0] ref_val,
                                   input logic [7:0] delta);
    logic [8:0] limit;
    limit = {1'b0, ref_val} + {1'b0, delta};
    exceeds = {1'b0, meas} > limit;
  endfunction : exceeds

  function automatic logic [7:0] read_mux(input logic [7:0] a, input top_s s,
                                          input logic [7:0] tim, input logic [7:0] err,
                                          input logic [7:0] coll);
    case (a)
      `ADDR_TIMER_NFC_IRQ: read_mux = tim;
      `ADDR_ERROR_WAKEUP_IRQ: read_mux = err;
      `ADDR_FIFO_FILL_COUNT: read_mux = {1'b0, s.fill_count}; // [R9]
      `ADDR_FIFO_FLAGS: read_mux = {1'b0, s.underflow, s.overflow, s.incomplete,
                                    s.last_bits, s.missing_parity};
      `ADDR_COLLISION_POSITION: read_mux = coll;
      `ADDR_WAKE_CONTROL: read_mux = {7'h00, s.wake_every_timeout};
      `ADDR_AMP_DELTA: read_mux = s.amp_delta;
      `ADDR_PHASE_DELTA: read_mux = s.phase_delta;
      `ADDR_CAP_DELTA: read_mux = s.cap_delta;
      default: read_mux = 8'h00;
    endcase
  endfunction : read_mux

  assign status_clear = set_default_cmd | clear_cmd; // [R10]
  assign missing_parity_evt = rx_end & last_no_parity;

  always_comb begin
    error_set = 8'h00;
    error_set[`ERR_BIT_CHECKSUM] = checksum_err_evt; // [R4]
    error_set[`ERR_BIT_PARITY] = parity_err_evt; // [R4]
    error_set[`ERR_BIT_SOFT_FRAMING] = soft_framing_evt | missing_parity_evt; // [R5] [R13]
    error_set[`ERR_BIT_HARD_FRAMING] = hard_framing_evt; // [R5]
    error_set[`ERR_BIT_WAKE_TIMEOUT] = wake_timeout_evt & cur.wake_every_timeout; // [R6]
    error_set[`ERR_BIT_AMPLITUDE] = amp_done & (exceeds(amp_meas, amp_ref, cur.amp_delta)
                                    | exceeds(amp_ref, amp_meas, cur.amp_delta)); // [R7]
    error_set[`ERR_BIT_PHASE] = phase_done
                                & exceeds(phase_meas, phase_ref, cur.phase_delta); // [R8]
    error_set[`ERR_BIT_CAPACITANCE] = cap_done & exceeds(cap_meas, cap_ref, cur.cap_delta); // [R8]
  end

  sticky_irq_reg #(
    .width(8)
  ) u_timer_irq (
    .clock(clock),
    .srst(srst),
    .force_clear(set_default_cmd), // [R2]
    .read_clear(rd_en && addr == `ADDR_TIMER_NFC_IRQ), // [R1]
    .set_evt(timer_nfc_evt),
    .flags(timer_flags)
  );

  sticky_irq_reg #(
    .width(8)
  ) u_error_irq (
    .clock(clock),
    .srst(srst),
    .force_clear(set_default_cmd), // [R2]
    .read_clear(rd_en && addr == `ADDR_ERROR_WAKEUP_IRQ), // [R3]
    .set_evt(error_set),
    .flags(error_flags)
  );

  collision_capture u_collision (
    .clock(clock),
    .srst(srst),
    .force_clear(status_clear),
    .frame_start(rx_start),
    .frame_end(rx_end),
    .coll_evt(coll_evt),
    .coll_bytes(coll_bytes),
    .coll_bits(coll_bits),
    .coll_parity(coll_parity),
    .position(coll_position),
    .parity_error(coll_parity_error)
  );

  always_comb begin
    nxt = cur;
    nxt.rd_data = rd_en ? read_mux(addr, cur, timer_flags, error_flags, coll_position)
                        : 8'h00;
    if (wr_en) begin
      case (addr)
        `ADDR_WAKE_CONTROL: nxt.wake_every_timeout = wr_data[0];
        `ADDR_AMP_DELTA: nxt.amp_delta = wr_data;
        `ADDR_PHASE_DELTA: nxt.phase_delta = wr_data;
        `ADDR_CAP_DELTA: nxt.cap_delta = wr_data;
        default: nxt.wake_every_timeout = cur.wake_every_timeout;
      endcase
    end
    nxt.fill_count = fifo_count;
    if (fifo_pop && fifo_count == 7'h00) begin
      nxt.underflow = 1'b1; // [R11]
    end
    if (fifo_push && fifo_count == `FIFO_DEPTH) begin
      nxt.overflow = 1'b1; // [R11]
    end
    if (rx_end) begin
      nxt.incomplete = last_incomplete; // [R12]
      nxt.last_bits = last_incomplete ? last_bits : 3'h0; // [R12]
      nxt.missing_parity = last_no_parity; // [R13]
    end
    if (fifo_count == 7'h00 && !rx_end) begin
      nxt.incomplete = 1'b0; // [R14]
      nxt.last_bits[1:0] = 2'h0; // [R14]
    end
    if (status_clear) begin
      nxt.fill_count = 7'h00; // [R10]
      nxt.underflow = 1'b0;
      nxt.overflow = 1'b0;
      nxt.incomplete = 1'b0;
      nxt.last_bits = 3'h0;
      nxt.missing_parity = 1'b0;
    end
    if (set_default_cmd) begin
      nxt.wake_every_timeout = 1'b0;
      nxt.amp_delta = `DELTA_RESET;
      nxt.phase_delta = `DELTA_RESET;
      nxt.cap_delta = `DELTA_RESET;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign rd_data = cur.rd_data;
  // summaries follow the detailed registers, so their reads and set default clear them
  assign timer_irq_pending = |timer_flags; // [R19]
  assign error_irq_pending = |error_flags; // [R19]
endmodule : irq_fifo_collision_status

// File: tb/irq_fifo_collision_status_assertions.sv
// port checks of the status register bank
`timescale 1ns/10ps
`include "irq_status_cfg.svh"
module irq_fifo_collision_status_assertions (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic set_default_cmd,
  input wire logic [7:0] timer_nfc_evt,
  input wire logic parity_err_evt,
  input wire logic rx_start,
  input wire logic rx_end,
  input wire logic coll_evt,
  input wire logic coll_parity,
  input wire logic coll_parity_error,
  input wire logic timer_irq_pending,
  input wire logic error_irq_pending
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence tim_read;
    rd_en && addr == `ADDR_TIMER_NFC_IRQ && timer_nfc_evt == 8'h00;
  endsequence
  sequence first_pcoll;
    rx_start ##1 (coll_evt && coll_parity && !rx_end);
  endsequence
  timer_clear_a: assert property (tim_read |=> !timer_irq_pending)
    else $error("timer register not cleared by its read");
  timer_hold_a: assert property (timer_irq_pending && !set_default_cmd
    && !(rd_en && addr == `ADDR_TIMER_NFC_IRQ) |=> timer_irq_pending)
    else $error("timer summary dropped without a read");
  timer_set_a: assert property (timer_nfc_evt != 8'h00 && !set_default_cmd
    |=> timer_irq_pending) else $error("timer event not recorded");
  parity_set_a: assert property (parity_err_evt && !set_default_cmd
    |=> error_irq_pending) else $error("parity error not recorded");
  err_hold_a: assert property (error_irq_pending && !set_default_cmd
    && !(rd_en && addr == `ADDR_ERROR_WAKEUP_IRQ) |=> error_irq_pending)
    else $error("error flags dropped without a read");
  default_clear_a: assert property (set_default_cmd
    |=> !timer_irq_pending && !error_irq_pending) else $error("set default left flags");
  coll_pe_a: assert property (first_pcoll |=> coll_parity_error)
    else $error("parity collision not flagged");
  pe_cause_a: assert property (coll_parity_error |-> $past(coll_evt) && $past(coll_parity)
    ##1 !coll_parity_error) else $error("parity collision flag without cause");
endmodule : irq_fifo_collision_status_assertions

bind irq_fifo_collision_status irq_fifo_collision_status_assertions checks (.clock, .srst,
  .addr, .rd_en, .set_default_cmd, .timer_nfc_evt, .parity_err_evt, .rx_start, .rx_end,
  .coll_evt, .coll_parity, .coll_parity_error, .timer_irq_pending, .error_irq_pending);

// File: tb/host_model.sv
// host model: drives the register port and collects read data
`timescale 1ns/10ps
module host_model (
  input wire logic clock,
  output logic [7:0] addr,
  output logic [7:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  input wire logic [7:0] rd_data
);
  initial begin
    addr = 8'h00;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    wr_data <= ~d;
  endtask : wr
  // data stand only in the cycle after the strobe, taken at its closing edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    addr <= ~a;
    @(posedge clock);
    d = rd_data;
  endtask : rd
endmodule : host_model

// File: tb/irq_fifo_collision_status_test.sv
// self-checking bench of the status register bank
`timescale 1ns/10ps
`include "irq_status_cfg.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, a, e); end end
module irq_fifo_collision_status_test;
  localparam logic [7:0] a_tim = `ADDR_TIMER_NFC_IRQ;
  localparam logic [7:0] a_err = `ADDR_ERROR_WAKEUP_IRQ;
  localparam logic [7:0] a_cnt = `ADDR_FIFO_FILL_COUNT;
  localparam logic [7:0] a_flg = `ADDR_FIFO_FLAGS;
  localparam logic [7:0] a_col = `ADDR_COLLISION_POSITION;
  logic clock = 0, srst = 1, set_default_cmd = 0, clear_cmd = 0, wake_timeout_evt = 0;
  logic [7:0] addr, wr_data, rd_data, v, timer_nfc_evt = 0, meas = 0, ref_v = 0, coll_bytes = 0;
  logic wr_en, rd_en, amp_done = 0, phase_done = 0, cap_done = 0, fifo_push = 0, fifo_pop = 0;
  logic rx_end = 0, last_incomplete = 0, last_no_parity = 0, rx_start = 0, coll_evt = 0;
  logic [2:0] last_bits = 0, coll_bits = 0;
  logic [3:0] ev = 0;
  logic [6:0] fifo_count = 0;
  logic coll_parity = 0, coll_parity_error, timer_irq_pending, error_irq_pending;
  int mismatches = 0, n_compared = 0;
  host_model host (.clock, .addr, .wr_data, .wr_en, .rd_en, .rd_data);
  irq_fifo_collision_status DUT (.clock, .srst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .set_default_cmd, .clear_cmd, .timer_nfc_evt, .checksum_err_evt(ev[3]),
    .parity_err_evt(ev[2]), .soft_framing_evt(ev[1]), .hard_framing_evt(ev[0]),
    .wake_timeout_evt, .amp_done, .amp_meas(meas), .amp_ref(ref_v), .phase_done,
    .phase_meas(meas), .phase_ref(ref_v), .cap_done, .cap_meas(meas), .cap_ref(ref_v),
    .fifo_count, .fifo_push, .fifo_pop, .rx_end, .last_incomplete, .last_bits,
    .last_no_parity, .rx_start, .coll_evt, .coll_bytes, .coll_bits, .coll_parity,
    .coll_parity_error, .timer_irq_pending, .error_irq_pending);
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic step();
    @(posedge clock);
  endtask : step
  task automatic expect_rd(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    `CHK(v, e)
  endtask : expect_rd
  // a frame with two collisions; only the first may be captured
  task automatic coll_frame(input logic [7:0] b, input logic p);
    rx_start <= 1;
    step();
    rx_start <= 0;
    coll_evt <= 1;
    coll_bytes <= b;
    coll_bits <= 3'h3;
    coll_parity <= p;
    step();
    coll_bytes <= 8'h05;
    step();
    `CHK(coll_parity_error, p)
    coll_evt <= 0;
    rx_end <= 1;
    step();
    rx_end <= 0;
  endtask : coll_frame
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5000) @(posedge clock);
    mismatches++;
    finish_test();
  end
  // enables, measurement, reference and expected error register per row
  logic [31:0] tbl [5] = '{32'h0405_0a04, 32'h0409_0500, 32'h0208_0502, 32'h0107_0500,
    32'h0108_0501};
  initial begin
    repeat (12) step();
    srst <= 0;
    for (int a = 8'h18; a <= 8'h1c; a++) expect_rd(a[7:0], 8'h00);
    for (int i = 0; i < 4; i++) begin
      ev <= 4'h8 >> i;
      step();
      ev <= 0;
      expect_rd(a_err, 8'h80 >> i);
      expect_rd(a_err, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      if (k == 1) host.wr(`ADDR_WAKE_CONTROL, 8'h01);
      wake_timeout_evt <= 1;
      step();
      wake_timeout_evt <= 0;
      expect_rd(a_err, (k == 1) ? 8'h08 : 8'h00);
    end
    host.wr(`ADDR_AMP_DELTA, 8'h04);
    host.wr(`ADDR_PHASE_DELTA, 8'h02);
    host.wr(`ADDR_CAP_DELTA, 8'h02);
    expect_rd(`ADDR_AMP_DELTA, 8'h04);
    foreach (tbl[j]) begin
      {amp_done, phase_done, cap_done} <= tbl[j][26:24];
      meas <= tbl[j][23:16];
      ref_v <= tbl[j][15:8];
      step();
      {amp_done, phase_done, cap_done} <= 3'b000;
      expect_rd(a_err, tbl[j][7:0]);
    end
    timer_nfc_evt <= 8'ha5;
    step();
    timer_nfc_evt <= 0;
    step();
    `CHK(timer_irq_pending, 1'b1)
    expect_rd(a_tim, 8'ha5);
    `CHK(timer_irq_pending, 1'b0)
    expect_rd(a_tim, 8'h00);
    ev <= 4'hf;
    set_default_cmd <= 1;
    step();
    ev <= 0;
    set_default_cmd <= 0;
    expect_rd(a_err, 8'h00);
    expect_rd(`ADDR_WAKE_CONTROL, 8'h00);
    fifo_count <= 7'h60;
    fifo_push <= 1;
    rx_end <= 1;
    last_incomplete <= 1;
    last_bits <= 3'h5;
    last_no_parity <= 1;
    step();
    fifo_push <= 0;
    rx_end <= 0;
    last_incomplete <= 0;
    last_no_parity <= 0;
    expect_rd(a_cnt, 8'h60);
    expect_rd(a_flg, 8'h3b);
    `CHK(error_irq_pending, 1'b1)
    expect_rd(a_err, 8'h20);
    `CHK(error_irq_pending, 1'b0)
    fifo_count <= 0;
    fifo_pop <= 1;
    step();
    fifo_pop <= 0;
    expect_rd(a_cnt, 8'h00);
    expect_rd(a_flg, 8'h69);
    clear_cmd <= 1;
    step();
    clear_cmd <= 0;
    expect_rd(a_flg, 8'h00);
    coll_frame(8'h02, 1'b1);
    expect_rd(a_col, 8'h27);
    clear_cmd <= 1;
    step();
    clear_cmd <= 0;
    expect_rd(a_col, 8'h00);
    coll_frame(8'h10, 1'b0);
    expect_rd(a_col, 8'h00);
    finish_test();
  end
endmodule : irq_fifo_collision_status_test
